//--- hdl/ssr_pkg.sv
// Behaviour
// - Marking idle line never starts a cycle.
// - Spacing start interval starts the cycle.
// - Running cycle is never restarted or aborted.
// - Stop impulse ends cycle; wait for start.
// - Sampled level held until next sample.
// - Five stages, set only when sampled marking.
// - Full pattern held until next start.
// - New start clears previous pattern first.
// - Sampling instant adjustable within each element.
// - Phase setting shifts stop; held until changed.
// - Disengaged cycle unit keeps position stationary.
// - Spacing unit advances one third, stops.
// - Line-feed unit advances one or two thirds.
// - Other four units run one full cycle.
// - One-unit elements, 1.42-unit marking stop.
package ssr_pkg;
    localparam int CLK_NS = 4;
    // One element at 22.8 dot cycles per second
    localparam longint UNIT_NS = 64'd21929825;
    localparam int UNIT_CYC = int'(UNIT_NS / CLK_NS);
    localparam int STOP_HUNDREDTHS = 142;
    localparam int CHAR_HUNDREDTHS = 600 + STOP_HUNDREDTHS;
    localparam int NUM_SEL = 5;
    localparam logic [2:0] ELEM_STOP = 3'h6;
    localparam int PHASE_W = 4;
    localparam logic [3:0] PHASE_MID = 4'h8;
    localparam int CYC_STEPS = 48;
    localparam int POS_W = 6;
    localparam int NUM_UNITS = 6;
    localparam int SPACE_UNIT = 0;
    localparam int LF_UNIT = 1;
    localparam int CODE_UNIT = 2;
    // One master revolution spans one character time
    localparam int TB_DIV_CYC =
        int'(64'(UNIT_CYC) * CHAR_HUNDREDTHS / (100 * CYC_STEPS));
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_PUSH} ssr_rx_state_t;

    typedef struct packed {
        logic frame_err;
        logic [NUM_SEL-1:0] code;
    } ssr_char_t;

    typedef struct packed {
        logic moving;
        logic [POS_W-1:0] pos;
    } ssr_unit_t;
endpackage

//--- hdl/ssr_receiver.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_fifo #(
    parameter int WIDTH = 6,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
        logic ov;
        logic [WIDTH-1:0] od;
    } ssr_fifo_st_t;

    ssr_fifo_st_t s;
    ssr_fifo_st_t next_s;
    logic do_wr;
    logic do_rd;

    assign in_ready = (s.cnt != FULL);
    assign out_valid = s.ov;
    assign out_data = s.od;

    always_comb begin
        next_s = s;
        do_wr = in_valid && (s.cnt != FULL);
        do_rd = (s.cnt != '0) && (!s.ov || out_ready);
        if (do_wr) begin
            next_s.mem[s.wp] = in_data;
            next_s.wp = (s.wp == LAST) ? '0 : s.wp + 1'b1;
        end
        if (do_rd) begin
            next_s.od = s.mem[s.rp];
            next_s.ov = 1'b1;
            next_s.rp = (s.rp == LAST) ? '0 : s.rp + 1'b1;
        end else if (out_ready) begin
            next_s.ov = 1'b0;
        end
        if (do_wr && !do_rd) begin
            next_s.cnt = s.cnt + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_s.cnt = s.cnt - 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end
endmodule // ssr_fifo

module ssr_receiver #(
    parameter int UNIT_CYCLES = ssr_pkg::UNIT_CYC,
    parameter int TB_DIV = ssr_pkg::TB_DIV_CYC,
    parameter int DEPTH = ssr_pkg::FIFO_DEPTH
) (
    // Clock, reset, enable
    input wire logic clock,
    input wire logic rst_b,
    input wire logic ce,
    // Line, marking high
    input wire logic line_mark,
    // Orientation setting
    input wire logic [ssr_pkg::PHASE_W-1:0] phase_set,
    input wire logic phase_load,
    output logic [ssr_pkg::PHASE_W-1:0] phase_now,
    // Receiver status
    output logic [ssr_pkg::NUM_SEL-1:0] pattern,
    output logic char_strobe,
    output logic busy,
    output logic line_level,
    // Cycle units
    input wire logic [ssr_pkg::NUM_UNITS-1:0] unit_trip,
    input wire logic lf_double,
    output ssr_pkg::ssr_unit_t [ssr_pkg::NUM_UNITS-1:0] units,
    // Character stream
    output ssr_pkg::ssr_char_t char_out,
    output logic char_valid,
    input wire logic char_ready
);
    localparam int THIRD = ssr_pkg::CYC_STEPS / 3;
    localparam logic [ssr_pkg::POS_W-1:0] LAST_POS = ssr_pkg::POS_W'(ssr_pkg::CYC_STEPS - 1);
    localparam logic [31:0] UNIT_LAST = 32'(UNIT_CYCLES - 1);
    localparam logic [31:0] TB_LAST = 32'(TB_DIV - 1);
    // Reset value of the sampling offset, mid-element phase
    localparam logic [31:0] OFF_MID = 32'((64'(UNIT_CYCLES) * 64'(ssr_pkg::PHASE_MID)) >> 4);

    typedef struct packed {
        ssr_pkg::ssr_rx_state_t st;
        logic line_q;
        logic line_lvl;
        logic [31:0] cnt;
        logic [31:0] offset;
        logic [2:0] elem;
        logic [ssr_pkg::NUM_SEL-1:0] pattern;
        logic strobe;
        logic busy;
        ssr_pkg::ssr_char_t pend;
        logic [ssr_pkg::PHASE_W-1:0] phase;
        logic [31:0] tb_div;
        ssr_pkg::ssr_unit_t [ssr_pkg::NUM_UNITS-1:0] units;
        logic [ssr_pkg::NUM_UNITS-1:0][ssr_pkg::POS_W-1:0] rem;
    } ssr_state_t;

    ssr_state_t s;
    ssr_state_t next_s;
    logic fifo_ready;
    logic sample_now;

    // Sampling point as a fraction of an element, in sixteenths
    function automatic logic [31:0] frac_off(input int unit, input logic [3:0] ph);
        logic [35:0] prod;
        prod = 36'(unit) * 36'(ph);
        return prod[35:4];
    endfunction

    function automatic logic [ssr_pkg::POS_W-1:0] unit_steps(input int idx, input logic dbl);
        logic [ssr_pkg::POS_W-1:0] n;
        n = ssr_pkg::POS_W'(ssr_pkg::CYC_STEPS);
        if (idx == ssr_pkg::SPACE_UNIT) begin
            n = ssr_pkg::POS_W'(THIRD);
        end else if (idx == ssr_pkg::LF_UNIT) begin
            n = dbl ? ssr_pkg::POS_W'(2 * THIRD) : ssr_pkg::POS_W'(THIRD);
        end
        return n;
    endfunction

    assign sample_now = (s.st == ssr_pkg::RX_RUN) && (s.cnt == s.offset);
    assign pattern = s.pattern;
    assign char_strobe = s.strobe;
    assign busy = s.busy;
    assign line_level = s.line_lvl;
    assign phase_now = s.phase;
    assign units = s.units;

    always_comb begin
        next_s = s;
        next_s.line_q = line_mark;
        next_s.strobe = 1'b0;
        if (phase_load) begin
            next_s.phase = phase_set;
        end
        case (s.st)
            ssr_pkg::RX_IDLE: begin
                // New phase only applies between characters
                next_s.offset = frac_off(UNIT_CYCLES, s.phase);
                if (s.line_q && !line_mark) begin
                    next_s.st = ssr_pkg::RX_RUN;
                    next_s.pattern = '0;
                    next_s.cnt = '0;
                    next_s.elem = '0;
                end
            end
            ssr_pkg::RX_RUN: begin
                // Line edges here do not touch the element count
                next_s.cnt = (s.cnt == UNIT_LAST) ? '0 : s.cnt + 1'b1;
                if (s.cnt == UNIT_LAST) begin
                    next_s.elem = s.elem + 1'b1;
                end
                if (sample_now) begin
                    next_s.line_lvl = line_mark;
                    if (s.elem != '0 && s.elem != ssr_pkg::ELEM_STOP) begin
                        next_s.pattern[s.elem - 1'b1] = line_mark;
                    end
                    if (s.elem == ssr_pkg::ELEM_STOP) begin
                        // Stop element is sampled inside its 1.42 units
                        next_s.strobe = 1'b1;
                        next_s.pend.code = s.pattern;
                        next_s.pend.frame_err = !line_mark;
                        next_s.st = ssr_pkg::RX_PUSH;
                    end
                end
            end
            ssr_pkg::RX_PUSH: begin
                // A full queue holds the receiver here; starts are missed
                if (fifo_ready) begin
                    next_s.st = ssr_pkg::RX_IDLE;
                end
            end
            default: begin
                next_s.st = ssr_pkg::RX_IDLE;
            end
        endcase

        next_s.busy = (next_s.st != ssr_pkg::RX_IDLE);
        next_s.tb_div = (s.tb_div == TB_LAST) ? '0 : s.tb_div + 1'b1;
        for (int i = 0; i < ssr_pkg::NUM_UNITS; i++) begin
            if (s.rem[i] != '0) begin
                if (s.tb_div == TB_LAST) begin
                    next_s.rem[i] = s.rem[i] - 1'b1;
                    next_s.units[i].pos =
                        (s.units[i].pos == LAST_POS) ? '0 : s.units[i].pos + 1'b1;
                end
            end else if (unit_trip[i] ||
                         (i == ssr_pkg::CODE_UNIT && s.strobe)) begin
                next_s.rem[i] = unit_steps(i, lf_double);
            end
            next_s.units[i].moving = (next_s.rem[i] != '0);
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            s <= '0;
            s.st <= ssr_pkg::RX_IDLE;
            s.line_q <= 1'b1;
            s.line_lvl <= 1'b1;
            s.phase <= ssr_pkg::PHASE_MID;
            s.offset <= OFF_MID;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ssr_fifo #(
        .WIDTH($bits(ssr_pkg::ssr_char_t)),
        .DEPTH(DEPTH)
    ) u_fifo (
        .clock(clock),
        .rst_b(rst_b),
        .ce(ce),
        .in_valid(s.st == ssr_pkg::RX_PUSH),
        .in_ready(fifo_ready),
        .in_data(s.pend),
        .out_valid(char_valid),
        .out_ready(char_ready),
        .out_data(char_out)
    );

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);

    a_idle_stays_idle: assert property (
        s.st == ssr_pkg::RX_IDLE && line_mark && ce |=> s.st == ssr_pkg::RX_IDLE)
        else $error("cycle began on a marking line");
    a_start_clears: assert property (
        s.st == ssr_pkg::RX_IDLE && s.line_q && !line_mark && ce
        |=> s.st == ssr_pkg::RX_RUN && s.pattern == '0 && s.cnt == '0)
        else $error("start interval did not begin a cleared cycle");
    a_run_no_abort: assert property (
        s.st == ssr_pkg::RX_RUN && s.elem != ssr_pkg::ELEM_STOP && ce
        |=> s.st == ssr_pkg::RX_RUN)
        else $error("character cycle left early");
    a_stop_strobe: assert property (
        sample_now && s.elem == ssr_pkg::ELEM_STOP && ce
        |=> s.strobe && s.st == ssr_pkg::RX_PUSH ##1 !s.strobe)
        else $error("stop element did not end the cycle with one strobe");
    a_level_held: assert property (
        !(sample_now && ce) |=> $stable(s.line_lvl))
        else $error("sampled level changed between samples");
    a_space_clear: assert property (
        sample_now && s.elem == 3'h1 && !line_mark && ce |=> !s.pattern[0])
        else $error("spaced element left its stage set");
    a_pattern_held: assert property (
        s.st != ssr_pkg::RX_RUN && !(s.line_q && !line_mark) |=> $stable(s.pattern))
        else $error("pattern changed before next start");
    a_offset_tracks: assert property (
        s.st == ssr_pkg::RX_IDLE && ce
        |=> s.offset == frac_off(UNIT_CYCLES, $past(s.phase)))
        else $error("sampling offset does not follow phase");
    a_phase_fixed: assert property (
        !(phase_load && ce) |=> $stable(s.phase))
        else $error("phase setting changed without a load");
    a_unit_still: assert property (
        !s.units[4].moving |=> $stable(s.units[4].pos))
        else $error("disengaged unit moved");
    a_space_third: assert property (
        $rose(s.units[ssr_pkg::SPACE_UNIT].moving)
        |-> s.rem[ssr_pkg::SPACE_UNIT] == ssr_pkg::POS_W'(THIRD))
        else $error("spacing unit not set for one third");
    a_lf_thirds: assert property (
        $rose(s.units[ssr_pkg::LF_UNIT].moving)
        |-> s.rem[ssr_pkg::LF_UNIT] ==
            ($past(lf_double) ? ssr_pkg::POS_W'(2 * THIRD) : ssr_pkg::POS_W'(THIRD)))
        else $error("line-feed unit step wrong");
    a_full_turn: assert property (
        $rose(s.units[3].moving) |-> s.rem[3] == ssr_pkg::POS_W'(ssr_pkg::CYC_STEPS))
        else $error("full-cycle unit not set for one turn");

    c_char_done: cover property (s.strobe);
    c_frame_err: cover property (s.strobe ##1 s.pend.frame_err);
    c_lf_double: cover property ($rose(s.units[ssr_pkg::LF_UNIT].moving) && $past(lf_double));
    c_queue_full: cover property (s.st == ssr_pkg::RX_PUSH && !fifo_ready);
endmodule // ssr_receiver

`default_nettype wire

//--- tb/ssr_line_sender.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_line_sender #(
    parameter int UNIT = 64
) (
    // Clock
    input wire logic clock,
    // Character request
    input wire logic go,
    input wire logic [4:0] code,
    input wire logic stop_space,
    // Line side
    output logic line_mark,
    output logic sending
);
    logic [4:0] c;

    initial begin
        line_mark = 1'b1;
        sending = 1'b0;
        forever begin
            @(posedge clock);
            if (go) begin
                c = code;
                sending <= 1'b1;
                line_mark <= 1'b0;
                repeat (UNIT) @(posedge clock);
                for (int i = 0; i < 5; i++) begin
                    line_mark <= c[i];
                    repeat (UNIT) @(posedge clock);
                end
                // Stop element lasts 1.42 units, spacing only on request
                line_mark <= ~stop_space;
                repeat (UNIT * 142 / 100) @(posedge clock);
                line_mark <= 1'b1;
                sending <= 1'b0;
            end
        end
    end
endmodule // ssr_line_sender

`default_nettype wire

//--- tb/ssr_receiver_test.sv
`timescale 1ns/1ps
`default_nettype none

module ssr_receiver_test;
    localparam int U = 64;
    logic clock, rst_b, line_mark, phase_load, char_strobe, busy, line_level;
    logic lf_double, char_valid, char_ready, go, stop_space, sending, busy_q;
    logic [3:0] phase_set, phase_now;
    logic [4:0] pattern, code, pat_at_start;
    logic [5:0] unit_trip;
    ssr_pkg::ssr_unit_t [5:0] units;
    ssr_pkg::ssr_char_t char_out, last_word;
    int failures = 0, comparisons = 0, strobes = 0, words = 0, run_len = 0, strobe_len = 0;

    ssr_receiver #(.UNIT_CYCLES(U), .TB_DIV(4), .DEPTH(16)) i_ssr_receiver (
        .clock(clock), .rst_b(rst_b), .ce(1'b1), .line_mark(line_mark),
        .phase_set(phase_set), .phase_load(phase_load), .phase_now(phase_now),
        .pattern(pattern), .char_strobe(char_strobe), .busy(busy),
        .line_level(line_level), .unit_trip(unit_trip), .lf_double(lf_double),
        .units(units), .char_out(char_out), .char_valid(char_valid),
        .char_ready(char_ready));

    ssr_line_sender #(.UNIT(U)) i_ssr_line_sender (
        .clock(clock), .go(go), .code(code), .stop_space(stop_space),
        .line_mark(line_mark), .sending(sending));

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // Observe settled outputs between edges
    always @(negedge clock) begin
        if (busy === 1'b1 && busy_q !== 1'b1) begin
            run_len = 0;
            pat_at_start = pattern;
        end else if (busy === 1'b1) begin
            run_len++;
        end
        if (char_strobe === 1'b1) begin
            strobes++;
            strobe_len = run_len;
        end
        if (char_valid === 1'b1 && char_ready === 1'b1) begin
            last_word = char_out;
            words++;
        end
        busy_q = busy;
    end

    task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic results();
        if (failures == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic send_char(input logic [4:0] c, input logic bad);
        int n;
        @(posedge clock);
        code <= c;
        stop_space <= bad;
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        @(negedge clock);
        for (n = 0; n < 1000 && sending !== 1'b0; n++) @(negedge clock);
        if (n == 1000) begin
            failures++;
            results();
        end
        repeat (4) @(negedge clock);
    endtask

    task automatic unit_run(input int k, input logic dbl, input int steps);
        int p0, n;
        @(posedge clock);
        lf_double <= dbl;
        unit_trip <= 6'(1 << k);
        @(negedge clock);
        p0 = int'(units[k].pos);
        @(posedge clock);
        unit_trip <= 6'h00;
        repeat (2) @(negedge clock);
        chk("unit moving", 1, units[k].moving);
        for (n = 0; n < 400 && units[k].moving !== 1'b0; n++) @(negedge clock);
        if (n == 400) begin
            failures++;
            results();
        end
        chk("unit pos", (p0 + steps) % 48, units[k].pos);
        repeat (40) @(negedge clock);
        chk("unit still", (p0 + steps) % 48, units[k].pos);
    endtask

    task automatic char_case(input logic [3:0] ph, input logic [4:0] c, input logic bad);
        @(posedge clock);
        phase_set <= ph;
        phase_load <= 1'b1;
        @(posedge clock);
        phase_load <= 1'b0;
        @(negedge clock);
        chk("phase now", ph, phase_now);
        send_char(c, bad);
        chk("start clear", 0, pat_at_start);
        chk("strobe time", 6 * U + U * ph / 16 + 1, strobe_len);
        chk("pattern", c, pattern);
        chk("line level", !bad, line_level);
        chk("word", {bad, c}, last_word);
    endtask

    task automatic idle_case();
        @(negedge clock);
        chk("reset phase", 8, phase_now);
        chk("reset idle", 0, {pattern, busy, char_valid, units});
        chk("reset level", 1, line_level);
        repeat (300) @(negedge clock);
        chk("idle busy", 0, busy);
        chk("idle strobes", 0, strobes);
    endtask

    // Fill the buffer with the consumer stalled, then drain
    task automatic fifo_stall();
        @(posedge clock);
        char_ready <= 1'b0;
        words = 0;
        for (int i = 0; i < 20; i++) send_char(5'(i), 1'b0);
        chk("stalled busy", 1, busy);
        @(posedge clock);
        char_ready <= 1'b1;
        for (int i = 0; i < 18; i++) begin
            @(negedge clock);
            chk("drain code", {1'b0, 5'(i)}, char_out);
        end
        repeat (20) @(negedge clock);
        chk("drained words", 18, words);
    endtask

    initial begin
        rst_b = 1'b0;
        phase_set = 4'h8;
        phase_load = 1'b0;
        unit_trip = 6'h00;
        lf_double = 1'b0;
        char_ready = 1'b1;
        go = 1'b0;
        code = 5'h00;
        stop_space = 1'b0;
        repeat (3) @(posedge clock);
        rst_b <= 1'b1;
        idle_case();
        unit_run(0, 1'b0, 16);
        unit_run(1, 1'b0, 16);
        unit_run(1, 1'b1, 32);
        for (int k = 2; k < 6; k++) unit_run(k, 1'b0, 48);
        char_case(4'h8, 5'h15, 1'b0);
        char_case(4'h0, 5'h0A, 1'b1);
        char_case(4'hF, 5'h1F, 1'b0);
        chk("pattern holds", 5'h1F, pattern);
        fifo_stall();
        results();
    end
endmodule // ssr_receiver_test

`default_nettype wire
